//--- verilog/autoneg_result_pkg.sv
package autoneg_result_pkg;
    localparam logic [4:0] DEV_ADDR = 5'h07;
    localparam logic [15:0] STATUS_OFFSET = 16'h8001;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam int NP_RX_BIT = 10;
    localparam int INC_LINK_BIT = 9;
    localparam int TX_LVL_LSB = 7;
    localparam int ROLE_LSB = 5;
    localparam int TECH_LSB = 1;
    localparam int DONE_BIT = 0;
    localparam logic [1:0] TX_LVL_NOT_RUN = 2'h0;
    localparam logic [1:0] TX_LVL_LOW = 2'h2;
    localparam logic [1:0] TX_LVL_HIGH = 2'h3;
    localparam logic [1:0] ROLE_NOT_RUN = 2'h0;
    localparam logic [1:0] ROLE_FAULT = 2'h1;
    localparam logic [1:0] ROLE_FOLLOWER = 2'h2;
    localparam logic [1:0] ROLE_LEADER = 2'h3;
    localparam logic [3:0] TECH_NULL = 4'h0;
    localparam logic [3:0] TECH_T1L = 4'h1;
endpackage

//--- verilog/autoneg_result_status.sv
`timescale 1ns/1ns
// Function
// - Register at 0x07/0x8001, resets to zero.
// - Bit 10 latches link partner next page.
// - Bit 9 updates only entering good-check.
// - Bits 8:7 report transmit level result.
// - Bits 6:5 report leader/follower result.
// - Bits 4:1 hold chosen technology code.
// - Bit 0 follows the link-good state input.
module autoneg_result_status (
    input wire logic mclk, // Management clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic [4:0] rd_dev, // Read device address.
    input wire logic [15:0] rd_addr, // Read register address.
    input wire logic rd_en, // Read strobe, one cycle.
    output logic [15:0] rd_data, // Read data, valid cycle after strobe.
    output logic rd_hit, // Read hit this register, registered.
    input wire logic next_page_rx, // Next page received pulse.
    input wire logic good_check_enter, // Entering good-check pulse.
    input wire logic incompatible_in, // Priority resolution: incompatible.
    input wire logic [1:0] tx_level_in, // Transmit level resolution.
    input wire logic [1:0] role_in, // Role resolution.
    input wire logic [3:0] tech_in, // Chosen technology code.
    input wire logic link_good_in // In link-good state.
);
    // ---------------------------------------------------------------
    // Check clocking
    // ---------------------------------------------------------------
    // All checks sample on the management clock and are dropped while
    // reset is asserted.
    default clocking check_cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // ---------------------------------------------------------------
    // Status fields
    // ---------------------------------------------------------------
    logic next_page_rx_flag_reg, next_page_rx_flag_next;
    logic incompatible_link_flag_reg, incompatible_link_flag_next;
    logic [1:0] tx_level_result_reg, tx_level_result_next;
    logic [1:0] role_resolution_result_reg, role_resolution_result_next;
    logic [3:0] common_technology_code_reg, common_technology_code_next;
    logic negotiation_done_flag_reg, negotiation_done_flag_next;
    logic [15:0] rd_data_reg, rd_data_next;
    logic rd_hit_reg, rd_hit_next;
    logic [15:0] status_word;
    logic hit;

    assign hit = rd_en && rd_dev == autoneg_result_pkg::DEV_ADDR
        && rd_addr == autoneg_result_pkg::STATUS_OFFSET;

    always_comb begin
        status_word = autoneg_result_pkg::STATUS_RESET;
        status_word[autoneg_result_pkg::NP_RX_BIT] = next_page_rx_flag_reg;
        status_word[autoneg_result_pkg::INC_LINK_BIT] =
            incompatible_link_flag_reg;
        status_word[autoneg_result_pkg::TX_LVL_LSB +: 2] =
            tx_level_result_reg;
        status_word[autoneg_result_pkg::ROLE_LSB +: 2] =
            role_resolution_result_reg;
        status_word[autoneg_result_pkg::TECH_LSB +: 4] =
            common_technology_code_reg;
        status_word[autoneg_result_pkg::DONE_BIT] = negotiation_done_flag_reg;
    end

    always_comb begin
        // A new request in the read cycle wins over the clear.
        next_page_rx_flag_next = next_page_rx
            || (next_page_rx_flag_reg && !hit);
        incompatible_link_flag_next = good_check_enter ? incompatible_in
            : incompatible_link_flag_reg;
        tx_level_result_next = tx_level_in;
        role_resolution_result_next = role_in;
        common_technology_code_next = tech_in;
        negotiation_done_flag_next = link_good_in;
        rd_data_next = hit ? status_word : autoneg_result_pkg::STATUS_RESET;
        rd_hit_next = hit;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            next_page_rx_flag_reg <= 1'b0;
            incompatible_link_flag_reg <= 1'b0;
            tx_level_result_reg <= autoneg_result_pkg::TX_LVL_NOT_RUN;
            role_resolution_result_reg <= autoneg_result_pkg::ROLE_NOT_RUN;
            common_technology_code_reg <= autoneg_result_pkg::TECH_NULL;
            negotiation_done_flag_reg <= 1'b0;
            rd_data_reg <= autoneg_result_pkg::STATUS_RESET;
            rd_hit_reg <= 1'b0;
        end else begin
            next_page_rx_flag_reg <= next_page_rx_flag_next;
            incompatible_link_flag_reg <= incompatible_link_flag_next;
            tx_level_result_reg <= tx_level_result_next;
            role_resolution_result_reg <= role_resolution_result_next;
            common_technology_code_reg <= common_technology_code_next;
            negotiation_done_flag_reg <= negotiation_done_flag_next;
            rd_data_reg <= rd_data_next;
            rd_hit_reg <= rd_hit_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_hit = rd_hit_reg;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // A next page request from the link partner in this cycle.
    sequence np_req_s;
        next_page_rx;
    endsequence

    // A read that decodes this register in this cycle.
    sequence read_req_s;
        hit;
    endsequence

    // Negotiation complete for a cycle, then the register is read.
    sequence done_then_read_s;
        link_good_in ##1 hit;
    endsequence

    // Negotiation not complete for a cycle, then the register is read.
    sequence open_then_read_s;
        !link_good_in ##1 hit;
    endsequence

    // ---------------------------------------------------------------
    // Read port checks
    // ---------------------------------------------------------------
    rd_hit_a: assert property (
        read_req_s |=> rd_hit)
        else $error("read of the status register not answered");

    rd_idle_a: assert property (
        !hit |=> !rd_hit && rd_data == autoneg_result_pkg::STATUS_RESET)
        else $error("read port active without a decoded read");

    rsvd_zero_a: assert property (
        rd_data >> (autoneg_result_pkg::NP_RX_BIT + 1) == '0)
        else $error("reserved bits not zero");

    // ---------------------------------------------------------------
    // Next page flag checks
    // ---------------------------------------------------------------
    np_latch_a: assert property (
        np_req_s |=> next_page_rx_flag_reg)
        else $error("next page flag not latched");

    np_hold_a: assert property (
        next_page_rx_flag_reg && !hit |=> next_page_rx_flag_reg)
        else $error("next page flag dropped without read");

    np_read_a: assert property (
        read_req_s |=> rd_data[autoneg_result_pkg::NP_RX_BIT]
            == $past(next_page_rx_flag_reg))
        else $error("next page flag misread");

    np_clear_a: assert property (
        hit && !next_page_rx |=> !next_page_rx_flag_reg)
        else $error("next page flag not cleared by read");

    np_set_wins_a: assert property (
        hit && next_page_rx |=> next_page_rx_flag_reg)
        else $error("next page arrival lost to a read");

    // ---------------------------------------------------------------
    // Incompatible link checks
    // ---------------------------------------------------------------
    inc_hold_a: assert property (
        !good_check_enter |=> $stable(incompatible_link_flag_reg))
        else $error("incompatible flag changed outside good check");

    inc_load_a: assert property (
        good_check_enter |=>
            incompatible_link_flag_reg == $past(incompatible_in))
        else $error("incompatible flag not loaded");

    inc_read_a: assert property (
        read_req_s |=> rd_data[autoneg_result_pkg::INC_LINK_BIT]
            == $past(incompatible_link_flag_reg))
        else $error("incompatible flag misread");

    // ---------------------------------------------------------------
    // Resolution result checks
    // ---------------------------------------------------------------
    tx_track_a: assert property (
        1'b1 |=> tx_level_result_reg == $past(tx_level_in))
        else $error("tx level field does not follow resolution");

    tx_read_a: assert property (
        read_req_s |=> rd_data[autoneg_result_pkg::TX_LVL_LSB +: 2]
            == $past(tx_level_result_reg))
        else $error("tx level field misread");

    role_track_a: assert property (
        1'b1 |=> role_resolution_result_reg == $past(role_in))
        else $error("role field does not follow resolution");

    role_read_a: assert property (
        read_req_s |=> rd_data[autoneg_result_pkg::ROLE_LSB +: 2]
            == $past(role_resolution_result_reg))
        else $error("role field misread");

    tech_track_a: assert property (
        1'b1 |=> common_technology_code_reg == $past(tech_in))
        else $error("technology field does not follow resolution");

    tech_read_a: assert property (
        read_req_s |=> rd_data[autoneg_result_pkg::TECH_LSB +: 4]
            == $past(common_technology_code_reg))
        else $error("technology field misread");

    // ---------------------------------------------------------------
    // Completion checks
    // ---------------------------------------------------------------
    done_track_a: assert property (
        1'b1 |=> negotiation_done_flag_reg == $past(link_good_in))
        else $error("done bit does not follow link good state");

    done_read_a: assert property (
        done_then_read_s |=> rd_data[autoneg_result_pkg::DONE_BIT])
        else $error("done bit not reported");

    done_low_read_a: assert property (
        open_then_read_s |=> !rd_data[autoneg_result_pkg::DONE_BIT])
        else $error("done bit reported too early");
endmodule

//--- dv/np_partner.sv
`timescale 1ns/1ns
module np_partner (
    input wire logic mclk, // Clock.
    input wire logic send, // Request one next page.
    output logic next_page_rx // Next page arrival pulse.
);
    initial next_page_rx = 1'b0;
    always @(posedge mclk) begin
        next_page_rx <= send;
    end
endmodule

//--- dv/autoneg_result_status_tb.sv
`timescale 1ns/1ns
module autoneg_result_status_tb;
    logic mclk = 1'b0, resetn = 1'b0, rd_en = 1'b0, rd_hit, send = 1'b0, np;
    logic gc = 1'b0, inc = 1'b0, lg = 1'b0;
    logic [4:0] rd_dev = 5'h00;
    logic [15:0] rd_addr = 16'h0000, rd_data;
    logic [1:0] tx = 2'h0, role = 2'h0;
    logic [3:0] tech = 4'h0;
    int err_count = 0, comparisons = 0;
    always #4 mclk = ~mclk;
    np_partner np_partner_i (.mclk(mclk), .send(send), .next_page_rx(np));
    autoneg_result_status autoneg_result_status_i (.mclk(mclk),
        .resetn(resetn), .rd_dev(rd_dev), .rd_addr(rd_addr), .rd_en(rd_en),
        .rd_data(rd_data), .rd_hit(rd_hit), .next_page_rx(np),
        .good_check_enter(gc), .incompatible_in(inc), .tx_level_in(tx),
        .role_in(role), .tech_in(tech), .link_good_in(lg));
    task chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task rd(logic [15:0] a, logic [15:0] e, logic h);
        @(posedge mclk) #1;
        rd_dev = autoneg_result_pkg::DEV_ADDR;
        rd_addr = a;
        rd_en = 1'b1;
        @(posedge mclk) #1;
        rd_en = 1'b0;
        chk("rd_data", e, rd_data);
        chk("rd_hit", {15'h0000, h}, {15'h0000, rd_hit});
    endtask
    task t_reset;
        rd(16'h8001, 16'h0000, 1'b1);
        rd(16'h8002, 16'h0000, 1'b0);
    endtask
    task t_next_page;
        @(posedge mclk) #1 send = 1'b1;
        @(posedge mclk) #1 send = 1'b0;
        repeat (2) @(posedge mclk);
        rd(16'h8002, 16'h0000, 1'b0);
        rd(16'h8001, 16'h0400, 1'b1);
        rd(16'h8001, 16'h0000, 1'b1);
    endtask
    task t_np_collide;
        fork
            begin
                @(posedge mclk);
                rd(16'h8001, 16'h0000, 1'b1);
            end
            begin
                @(posedge mclk) #1 send = 1'b1;
                @(posedge mclk) #1 send = 1'b0;
            end
        join
        rd(16'h8001, 16'h0400, 1'b1);
        rd(16'h8001, 16'h0000, 1'b1);
    endtask
    task t_fields;
        logic [1:0] txs [4];
        txs = '{2'h0, 2'h2, 2'h3, 2'h2};
        inc = 1'b1;
        for (int i = 0; i < 4; i++) begin
            tx = txs[i];
            role = 2'(i);
            tech = {3'h0, i[1]};
            lg = i[0];
            repeat (2) @(posedge mclk);
            rd(16'h8001, {7'h00, tx, role, tech, lg}, 1'b1);
        end
        @(posedge mclk) #1 gc = 1'b1;
        @(posedge mclk) #1 gc = 1'b0;
        inc = 1'b0;
        repeat (2) @(posedge mclk);
        rd(16'h8001, {7'h01, tx, role, tech, lg}, 1'b1);
        rd(16'h8001, {7'h01, tx, role, tech, lg}, 1'b1);
    endtask
    task t_mid_reset;
        @(posedge mclk) #1 send = 1'b1;
        @(posedge mclk) #1 send = 1'b0;
        repeat (2) @(posedge mclk);
        #1 resetn = 1'b0;
        repeat (2) @(posedge mclk);
        #1 resetn = 1'b1;
        rd(16'h8001, {7'h00, tx, role, tech, lg}, 1'b1);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1 resetn = 1'b1;
        t_reset();
        t_next_page();
        t_np_collide();
        t_fields();
        t_mid_reset();
        summarize();
    end
    initial begin
        #20000;
        err_count++;
        summarize();
    end
endmodule
